//--- inc/dnc_pkg.sv
// Package: register map, reset values and field positions for the binding and sync block
package dnc_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] OFS_BIND = 12'h216;
	localparam logic [11:0] OFS_RDIV = 12'h217;
	localparam logic [11:0] OFS_SYNC = 12'h219;
	localparam logic [11:0] OFS_CTRL = 12'h21A;
	localparam logic [11:0] OFS_STAT = 12'h21B;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_BIND = 8'h02;
	localparam logic [15:0] RST_RDIV = 16'h0000;
	localparam logic [7:0] RST_SYNC = 8'h02;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIND_A_POS = 0;
	localparam int BIND_B_POS = 1;
	localparam int SYNC_NEXT_POS = 0;
	localparam int SYNC_LINK_POS = 1;
	localparam int CTRL_PDA_POS = 0;
	localparam int CTRL_PDB_POS = 1;
	localparam int CTRL_LINK_EN_POS = 2;
	localparam int CTRL_CAL_EN_POS = 3;
	localparam int CTRL_SINGLE_POS = 4;
	localparam int CTRL_ENC64_POS = 5;
	// ****************************************
	// Arming states
	// ****************************************
	typedef enum logic [1:0] {ARM_IDLE, ARM_PRIMED, ARM_ARMED} dnc_arm_t;
endpackage

//--- inc/dnc_sync_if.sv
// Interface: phase sync configuration and resulting init pulse between core and sync unit
`timescale 1ns/1ps
interface dnc_sync_if;
	logic init_on_link;
	logic arm_bit;
	logic arm_write;
	logic enc64;
	logic link_sync;
	logic sysref;
	logic lmfc_edge;
	logic phase_init;
	logic armed;
	modport core (output init_on_link, arm_bit, arm_write, enc64, link_sync, sysref, lmfc_edge,
		input phase_init, armed);
	modport unit (input init_on_link, arm_bit, arm_write, enc64, link_sync, sysref, lmfc_edge,
		output phase_init, armed);
endinterface

//--- testbench/dnc_ctrl_properties.sv
// Checker: port-level properties of the binding and sync control block
`timescale 1ns/1ps
module dnc_ctrl_properties (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [11:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire logic SEL_DIG_A_FROM_B,
	input wire logic SEL_DIG_B_FROM_B,
	input wire logic PD_DIG_A,
	input wire logic PD_DIG_B,
	input wire logic PD_CONV_A,
	input wire logic PD_CONV_B,
	input wire logic LINK_ENABLE,
	input wire logic LINK_RESYNC_REQ,
	input wire logic [15:0] REF_DIVISOR,
	input wire logic REF_DIV_ACTIVE,
	input wire logic PHASE_INIT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_wr_bind;
		REG_WR && REG_ADDR == dnc_pkg::OFS_BIND;
	endsequence
	sequence s_rd_narrow;
		REG_RD && (REG_ADDR == dnc_pkg::OFS_BIND || REG_ADDR == dnc_pkg::OFS_SYNC);
	endsequence
	chk_bind_b_sel: assert property (s_wr_bind |=> SEL_DIG_B_FROM_B == $past(REG_WDATA[1]))
		else $error("digital B source differs from written bit");
	chk_bind_a_sel: assert property (s_wr_bind |=> SEL_DIG_A_FROM_B == $past(REG_WDATA[0]))
		else $error("digital A source differs from written bit");
	chk_pd_follow_a: assert property (PD_DIG_A == (SEL_DIG_A_FROM_B ? PD_CONV_B : PD_CONV_A))
		else $error("digital A power-down not following bound converter");
	chk_pd_follow_b: assert property (PD_DIG_B == (SEL_DIG_B_FROM_B ? PD_CONV_B : PD_CONV_A))
		else $error("digital B power-down not following bound converter");
	chk_div_active: assert property (REF_DIV_ACTIVE == (REF_DIVISOR != 16'h0000))
		else $error("divisor active flag wrong");
	chk_div_write: assert property (REG_WR && REG_ADDR == dnc_pkg::OFS_RDIV |=>
		REF_DIVISOR == $past(REG_WDATA)) else $error("divisor not loaded");
	chk_rsvd_read: assert property (s_rd_narrow |=> REG_RDATA[15:2] == 14'h0000)
		else $error("reserved bits read nonzero");
	chk_init_single: assert property (PHASE_INIT |=> !PHASE_INIT [*3])
		else $error("phase init repeated");
	chk_resync_gate: assert property (LINK_RESYNC_REQ |-> LINK_ENABLE)
		else $error("resync request with link off");
endmodule // dnc_ctrl_properties
bind dnc_ctrl dnc_ctrl_properties i_props (.*);

//--- testbench/dnc_far_end.sv
// Partner: link receiver sync, boundary marker and SYSREF source
`timescale 1ns/1ps
module dnc_far_end (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_rel,
	input wire logic sysref_go,
	output logic link_sync_n,
	output logic sysref,
	output logic lmfc_edge
);
	logic [2:0] frame_q;
	logic [2:0] ref_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) frame_q <= 3'h0;
		else frame_q <= frame_q + 3'h1;
	end
	assign lmfc_edge = frame_q == 3'h7;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) link_sync_n <= 1'b0;
		else link_sync_n <= sync_rel;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ref_q <= 3'h0;
		else if (sysref_go) ref_q <= 3'h4;
		else if (ref_q != 3'h0) ref_q <= ref_q - 3'h1;
	end
	assign sysref = ref_q != 3'h0;
endmodule // dnc_far_end

//--- testbench/tb_top.sv
// Testbench: register access, binding, divisor and phase init tests
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sync_rel = 1'b0;
	logic sysref_go = 1'b0;
	logic link_sync_n, sysref, lmfc_edge, sel_a, sel_b, pd_a, pd_b, link_en, resync, div_act, init;
	logic pdc_a, pdc_b, cal_en;
	logic [15:0] reg_rdata, ref_div;
	int bad_count = 0;
	int n_tests = 0;
	int pulses = 0;
	int cycles = 0;
	dnc_far_end i_far (.clk(core_clk), .rst_n(rst_n), .sync_rel(sync_rel), .sysref_go(sysref_go),
		.link_sync_n(link_sync_n), .sysref(sysref), .lmfc_edge(lmfc_edge));
	dnc_ctrl i_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.LINK_SYNC_N(link_sync_n), .SYSREF(sysref), .LMFC_EDGE(lmfc_edge),
		.SEL_DIG_A_FROM_B(sel_a), .SEL_DIG_B_FROM_B(sel_b), .PD_DIG_A(pd_a), .PD_DIG_B(pd_b),
		.PD_CONV_A(pdc_a), .PD_CONV_B(pdc_b), .LINK_ENABLE(link_en), .CAL_ENABLE(cal_en),
		.LINK_RESYNC_REQ(resync), .REF_DIVISOR(ref_div), .REF_DIV_ACTIVE(div_act),
		.PHASE_INIT(init));
	initial forever #5 core_clk = ~core_clk;
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (init === 1'b1) pulses++;
		if (cycles == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [11:0] a, input logic [15:0] m, input logic [15:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata & m, exp);
	endtask
	task fire;
		pulses = 0;
		sysref_go <= 1'b1;
		tick(1);
		sysref_go <= 1'b0;
		tick(15);
	endtask
	initial begin
		tick(10);
		rst_n <= 1'b1;
		rd(dnc_pkg::OFS_BIND, 16'hFFFF, 16'h0002);
		rd(dnc_pkg::OFS_RDIV, 16'hFFFF, 16'h0000);
		rd(dnc_pkg::OFS_SYNC, 16'hFFFF, 16'h0002);
		rd(12'h218, 16'hFFFF, 16'h0000);
		$display("reset test done");
		for (int b = 0; b < 4; b++) begin
			wr(dnc_pkg::OFS_CTRL, 16'h0000);
			wr(dnc_pkg::OFS_BIND, 16'h00FC | 16'(b));
			rd(dnc_pkg::OFS_BIND, 16'hFFFF, 16'(b));
			check(16'(sel_a), 16'(b & 1));
			check(16'(sel_b), 16'(b >> 1));
			for (int p = 0; p < 4; p++) begin
				wr(dnc_pkg::OFS_CTRL, 16'(p));
				check(16'({pdc_b, pdc_a}), 16'(p));
				check(16'(pd_a), 16'((p >> (b & 1)) & 1));
				check(16'(pd_b), 16'((p >> (b >> 1)) & 1));
			end
		end
		wr(dnc_pkg::OFS_CTRL, 16'h0000);
		wr(dnc_pkg::OFS_BIND, 16'h0002);
		$display("binding test done");
		wr(dnc_pkg::OFS_RDIV, 16'h2000);
		rd(dnc_pkg::OFS_RDIV, 16'hFFFF, 16'h2000);
		check(ref_div, 16'h2000);
		check(16'(div_act), 16'h0001);
		wr(dnc_pkg::OFS_RDIV, 16'h0000);
		check(16'(div_act), 16'h0000);
		$display("divisor test done");
		wr(dnc_pkg::OFS_CTRL, 16'h000F);
		check(16'(cal_en), 16'h0001);
		check(16'(link_en), 16'h0000);
		wr(dnc_pkg::OFS_CTRL, 16'h0004);
		check(16'(link_en), 16'h0001);
		tick(5);
		check(16'(resync), 16'h0001);
		pulses = 0;
		sync_rel <= 1'b1;
		tick(24);
		check(16'(pulses), 16'h0001);
		wr(dnc_pkg::OFS_CTRL, 16'h0024);
		sync_rel <= 1'b0;
		tick(5);
		check(16'(resync), 16'h0000);
		pulses = 0;
		sync_rel <= 1'b1;
		tick(24);
		check(16'(pulses), 16'h0001);
		$display("link sync test done");
		wr(dnc_pkg::OFS_SYNC, 16'h0000);
		wr(dnc_pkg::OFS_SYNC, 16'h0001);
		rd(dnc_pkg::OFS_STAT, 16'h0008, 16'h0008);
		fire();
		check(16'(pulses), 16'h0001);
		fire();
		check(16'(pulses), 16'h0000);
		wr(dnc_pkg::OFS_SYNC, 16'h0001);
		fire();
		check(16'(pulses), 16'h0000);
		wr(dnc_pkg::OFS_SYNC, 16'h0000);
		wr(dnc_pkg::OFS_SYNC, 16'h0001);
		fire();
		check(16'(pulses), 16'h0001);
		$display("sysref test done");
		end_of_test();
	end
endmodule // tb_top

//--- verilog/dnc_ctrl.sv
// Channel binding, reference divisor and phase sync control top
//
// Overview of operation
// - Binding bit 1 picks converter A or B for digital channel B; resets 1.
// - Binding bit 0 picks converter A or B for digital channel A; resets 0.
// - Digital channel powers down when its bound converter is down; link only when both channels are down.
// - Divisor zero disables it; nonzero gives exact step; 16 bits wide.
// - One divisor serves every oscillator preset.
// - Link-sync bit set inits phase at boundary after sync rises.
// - In 64b/66b the sync input only inits phase, never the link.
// - Writing arm bit 0 then 1 arms init on next SYSREF rise.
// - After one SYSREF init, further edges ignored until rearmed.
`timescale 1ns/1ps
module dnc_ctrl (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [11:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	input wire logic LINK_SYNC_N,
	input wire logic SYSREF,
	input wire logic LMFC_EDGE,
	output logic SEL_DIG_A_FROM_B,
	output logic SEL_DIG_B_FROM_B,
	output logic PD_DIG_A,
	output logic PD_DIG_B,
	output logic PD_CONV_A,
	output logic PD_CONV_B,
	output logic LINK_ENABLE,
	output logic CAL_ENABLE,
	output logic LINK_RESYNC_REQ,
	output logic [15:0] REF_DIVISOR,
	output logic REF_DIV_ACTIVE,
	output logic PHASE_INIT
);
	logic [1:0] bind_q;
	logic [15:0] rdiv_q;
	logic [1:0] sync_q;
	logic [5:0] ctrl_q;
	logic [15:0] rdata_q;
	logic [1:0] syncn_meta_q;
	logic [1:0] syncn_q;
	logic [1:0] sysref_meta_q;
	logic [1:0] sysref_q;
	logic wr_bind;
	logic wr_rdiv;
	logic wr_sync;
	logic wr_ctrl;
	logic link_sync_hi;

	dnc_sync_if sif ();

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs, input logic s);
		hit = s & (a == ofs);
	endfunction

	assign wr_bind = hit(REG_ADDR, dnc_pkg::OFS_BIND, REG_WR);
	assign wr_rdiv = hit(REG_ADDR, dnc_pkg::OFS_RDIV, REG_WR);
	assign wr_sync = hit(REG_ADDR, dnc_pkg::OFS_SYNC, REG_WR);
	assign wr_ctrl = hit(REG_ADDR, dnc_pkg::OFS_CTRL, REG_WR);

	// ****************************************
	// Register writes
	// ****************************************
	// Reserved bits dropped
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bind_q <= dnc_pkg::RST_BIND[1:0];
		end else if (wr_bind) begin
			bind_q <= REG_WDATA[1:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdiv_q <= dnc_pkg::RST_RDIV;
		end else if (wr_rdiv) begin
			rdiv_q <= REG_WDATA;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_q <= dnc_pkg::RST_SYNC[1:0];
		end else if (wr_sync) begin
			sync_q <= REG_WDATA[1:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= dnc_pkg::RST_CTRL[5:0];
		end else if (wr_ctrl) begin
			ctrl_q <= REG_WDATA[5:0];
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	// Unmapped addresses read zero
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 16'h0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				dnc_pkg::OFS_BIND: rdata_q <= {14'h0000, bind_q};
				dnc_pkg::OFS_RDIV: rdata_q <= rdiv_q;
				dnc_pkg::OFS_SYNC: rdata_q <= {14'h0000, sync_q};
				dnc_pkg::OFS_CTRL: rdata_q <= {10'h000, ctrl_q};
				dnc_pkg::OFS_STAT: rdata_q <= {12'h000, sif.armed, link_sync_hi,
					PD_DIG_B, PD_DIG_A};
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign REG_RDATA = rdata_q;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Four stages to the sync unit since both pins are asynchronous to the core clock
	// Sync resets asserted, as the receiver holds it low until the link is up
	// A high reset value would read as a false release right after reset
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			syncn_meta_q <= 2'h0;
			syncn_q <= 2'h0;
			sysref_meta_q <= 2'h0;
			sysref_q <= 2'h0;
		end else begin
			syncn_meta_q <= {syncn_meta_q[0], LINK_SYNC_N};
			syncn_q <= {syncn_q[0], syncn_meta_q[1]};
			sysref_meta_q <= {sysref_meta_q[0], SYSREF};
			sysref_q <= {sysref_q[0], sysref_meta_q[1]};
		end
	end
	assign link_sync_hi = syncn_meta_q[1];

	// ****************************************
	// Binding and power down
	// ****************************************
	// Channel A source
	assign SEL_DIG_A_FROM_B = bind_q[dnc_pkg::BIND_A_POS];
	assign SEL_DIG_B_FROM_B = bind_q[dnc_pkg::BIND_B_POS];
	assign PD_CONV_A = ctrl_q[dnc_pkg::CTRL_PDA_POS];
	assign PD_CONV_B = ctrl_q[dnc_pkg::CTRL_PDB_POS];
	assign PD_DIG_A = SEL_DIG_A_FROM_B ? PD_CONV_B : PD_CONV_A;
	assign PD_DIG_B = SEL_DIG_B_FROM_B ? PD_CONV_B : PD_CONV_A;
	// Link is held off if both of its channels are down
	assign LINK_ENABLE = ctrl_q[dnc_pkg::CTRL_LINK_EN_POS] & ~(PD_DIG_A & PD_DIG_B);
	assign CAL_ENABLE = ctrl_q[dnc_pkg::CTRL_CAL_EN_POS];

	// ****************************************
	// Reference divisor
	// ****************************************
	// Zero means plain accumulator
	assign REF_DIVISOR = rdiv_q;
	assign REF_DIV_ACTIVE = (rdiv_q != 16'h0000);

	// ****************************************
	// Phase sync
	// ****************************************
	assign sif.init_on_link = sync_q[dnc_pkg::SYNC_LINK_POS];
	assign sif.arm_bit = REG_WDATA[dnc_pkg::SYNC_NEXT_POS];
	assign sif.arm_write = wr_sync;
	assign sif.enc64 = ctrl_q[dnc_pkg::CTRL_ENC64_POS];
	assign sif.link_sync = syncn_q[1];
	assign sif.sysref = sysref_q[1];
	assign sif.lmfc_edge = LMFC_EDGE;

	// Sync low reaches link only in 8b/10b
	assign LINK_RESYNC_REQ = ~sif.enc64 & ~syncn_q[1] & LINK_ENABLE;

	dnc_phase_sync u_sync (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.sif(sif)
	);
	assign PHASE_INIT = sif.phase_init;
endmodule // dnc_ctrl

//--- verilog/dnc_phase_sync.sv
// Phase initialisation unit: link sync boundary and armed SYSREF edge
`timescale 1ns/1ps
module dnc_phase_sync (
	input wire logic clk,
	input wire logic rst_n,
	dnc_sync_if.unit sif
);
	logic link_q;
	logic sysref_q;
	logic pend_q;
	logic init_q;
	logic link_rise;
	logic sysref_rise;
	dnc_pkg::dnc_arm_t arm_q;

	assign link_rise = sif.link_sync & ~link_q;
	assign sysref_rise = sif.sysref & ~sysref_q;
	assign sif.phase_init = init_q;
	assign sif.armed = (arm_q == dnc_pkg::ARM_ARMED);

	// ****************************************
	// Edge history
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_q <= 1'b0;
			sysref_q <= 1'b0;
		end else begin
			link_q <= sif.link_sync;
			sysref_q <= sif.sysref;
		end
	end

	// ****************************************
	// Link sync path
	// ****************************************
	// Wait for boundary
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (!sif.init_on_link) begin
			pend_q <= 1'b0;
		end else if (link_rise) begin
			pend_q <= 1'b1;
		end else if (sif.lmfc_edge) begin
			pend_q <= 1'b0;
		end
	end

	// ****************************************
	// SYSREF arming
	// ****************************************
	// Zero then one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_q <= dnc_pkg::ARM_IDLE;
		end else if (sif.arm_write) begin
			if (!sif.arm_bit) begin
				arm_q <= dnc_pkg::ARM_PRIMED;
			end else if (arm_q == dnc_pkg::ARM_PRIMED) begin
				arm_q <= dnc_pkg::ARM_ARMED;
			end
		end else begin
			case (arm_q)
				dnc_pkg::ARM_ARMED: begin
					if (sysref_rise) begin
						arm_q <= dnc_pkg::ARM_IDLE;
					end
				end
				default: begin
					arm_q <= arm_q;
				end
			endcase
		end
	end

	// ****************************************
	// Init pulse
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_q <= 1'b0;
		end else begin
			init_q <= (sif.init_on_link & pend_q & sif.lmfc_edge)
				| (arm_q == dnc_pkg::ARM_ARMED & sysref_rise & ~sif.arm_write);
		end
	end
endmodule // dnc_phase_sync
